/* hw/modem_mode_pkg.sv */
// Package with control-bus addresses, field positions and tone tables for the mode decode
package modem_mode_pkg;

    // ----------------------------------------------------------------
    // Control-bus addresses
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_GENERAL_RESET = 8'h01;
    localparam logic [7:0] ADDR_GENERAL_CTRL = 8'hE0;
    localparam logic [7:0] ADDR_TX_MODE = 8'hE1;
    localparam logic [7:0] ADDR_RX_MODE = 8'hE2;

    localparam logic [4:0] ADDR_LAST_BIT = 5'h07;
    localparam logic [4:0] WORD_LAST_BIT = 5'h17;
    localparam logic [4:0] ADDR_BITS = 5'h08;

    // ----------------------------------------------------------------
    // Reset values and field positions
    // ----------------------------------------------------------------
    localparam logic [15:0] MODE_RESET = 16'h0000;
    localparam int GEN_RESET_BIT = 7;
    localparam int MODE_MSB = 15;
    localparam int MODE_LSB = 12;
    localparam int GAIN_MSB = 11;
    localparam int GAIN_LSB = 9;
    localparam int EQ_BIT = 8;
    localparam int FMT_MSB = 4;
    localparam int FMT_LSB = 3;
    localparam int TONE_BANK_BIT = 4;

    // ----------------------------------------------------------------
    // Mode codes
    // ----------------------------------------------------------------
    localparam logic [3:0] MODE_OFF = 4'h0;
    localparam logic [3:0] MODE_TONES = 4'h1;
    localparam logic [2:0] MODE_BELL202 = 3'h1;
    localparam logic [2:0] MODE_V23 = 3'h2;
    localparam logic [2:0] MODE_BELL103 = 3'h3;
    localparam logic [2:0] MODE_V21 = 3'h4;
    localparam logic [2:0] MODE_DPSK600 = 3'h5;
    localparam logic [2:0] MODE_DPSK1200 = 3'h6;
    localparam logic [2:0] MODE_RESERVED = 3'h7;

    localparam logic [1:0] FMT_SYNC = 2'h3;
    localparam logic [1:0] FMT_NO_PARITY = 2'h2;
    localparam logic [1:0] FMT_EVEN = 2'h1;
    localparam logic [1:0] FMT_ODD = 2'h0;

    localparam logic [3:0] MIN_DATA_BITS = 4'h5;
    localparam logic [7:0] GAIN_STEP_TENTH_DB = 8'h0F;
    localparam logic [7:0] GAIN_FLOOR_TENTH_DB = 8'h69;

    typedef enum logic [1:0] {
        SRC_BUFFER = 2'b00,
        SRC_ONES = 2'b01,
        SRC_ZEROS = 2'b10,
        SRC_PATTERN = 2'b11
    } tx_source_e;

    // ----------------------------------------------------------------
    // Tone frequencies in Hz
    // ----------------------------------------------------------------
    localparam logic [11:0] HZ_NONE = 12'h000;
    localparam logic [11:0] HZ_697 = 12'd697;
    localparam logic [11:0] HZ_770 = 12'd770;
    localparam logic [11:0] HZ_852 = 12'd852;
    localparam logic [11:0] HZ_941 = 12'd941;
    localparam logic [11:0] HZ_1209 = 12'd1209;
    localparam logic [11:0] HZ_1336 = 12'd1336;
    localparam logic [11:0] HZ_1477 = 12'd1477;
    localparam logic [11:0] HZ_1633 = 12'd1633;
    localparam logic [11:0] HZ_1300 = 12'd1300;
    localparam logic [11:0] HZ_2100 = 12'd2100;
    localparam logic [11:0] HZ_2225 = 12'd2225;

endpackage

/* hw/tx_tone_decode.sv */
// Decoder of the transmit tone selection into frequencies and programmed-pair strobes
`timescale 1ns/100ps
`default_nettype none

module tx_tone_decode
    import modem_mode_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic tone_mode,
    input wire logic [4:0] tone_sel,
    output logic [11:0] tone_low_hz,
    output logic [11:0] tone_high_hz,
    output logic programmed_tone_pair_a,
    output logic programmed_tone_pair_b,
    output logic programmed_tone_pair_c,
    output logic programmed_tone_pair_d
);

    logic [11:0] row_hz;
    logic [11:0] col_hz;
    logic [3:0] prog_sel;

    // ----------------------------------------------------------------
    // Keypad row and column lookup
    // ----------------------------------------------------------------
    always_comb
    begin
        row_hz = HZ_NONE;
        col_hz = HZ_NONE;
        case (tone_sel[3:0])
            4'h0: begin row_hz = HZ_941; col_hz = HZ_1633; end
            4'h1: begin row_hz = HZ_697; col_hz = HZ_1209; end
            4'h2: begin row_hz = HZ_697; col_hz = HZ_1336; end
            4'h3: begin row_hz = HZ_697; col_hz = HZ_1477; end
            4'h4: begin row_hz = HZ_770; col_hz = HZ_1209; end
            4'h5: begin row_hz = HZ_770; col_hz = HZ_1336; end
            4'h6: begin row_hz = HZ_770; col_hz = HZ_1477; end
            4'h7: begin row_hz = HZ_852; col_hz = HZ_1209; end
            4'h8: begin row_hz = HZ_852; col_hz = HZ_1336; end
            4'h9: begin row_hz = HZ_852; col_hz = HZ_1477; end
            4'hA: begin row_hz = HZ_941; col_hz = HZ_1336; end
            4'hB: begin row_hz = HZ_941; col_hz = HZ_1209; end
            4'hC: begin row_hz = HZ_941; col_hz = HZ_1477; end
            4'hD: begin row_hz = HZ_697; col_hz = HZ_1633; end
            4'hE: begin row_hz = HZ_770; col_hz = HZ_1633; end
            4'hF: begin row_hz = HZ_852; col_hz = HZ_1633; end
            default: begin row_hz = HZ_NONE; col_hz = HZ_NONE; end
        endcase
    end

    // ----------------------------------------------------------------
    // Output selection
    // ----------------------------------------------------------------
    // Programmed pairs carry no frequency here; the tone generator holds them
    always_comb
    begin
        tone_low_hz = HZ_NONE;
        tone_high_hz = HZ_NONE;
        prog_sel = 4'h0;
        if (tone_mode && tone_sel[TONE_BANK_BIT])
        begin
            tone_low_hz = row_hz;
            tone_high_hz = col_hz;
        end
        else if (tone_mode)
        begin
            case (tone_sel[3:0])
                4'h1: tone_low_hz = HZ_697;
                4'h2: tone_low_hz = HZ_770;
                4'h3: tone_low_hz = HZ_852;
                4'h4: tone_low_hz = HZ_941;
                4'h5: tone_low_hz = HZ_1209;
                4'h6: tone_low_hz = HZ_1336;
                4'h7: tone_low_hz = HZ_1477;
                4'h8: tone_low_hz = HZ_1633;
                4'h9: tone_low_hz = HZ_1300;
                4'hA: tone_low_hz = HZ_2100;
                4'hB: tone_low_hz = HZ_2225;
                4'hC: prog_sel = 4'h1;
                4'hD: prog_sel = 4'h2;
                4'hE: prog_sel = 4'h4;
                4'hF: prog_sel = 4'h8;
                default: tone_low_hz = HZ_NONE;
            endcase
        end
    end

    assign programmed_tone_pair_a = prog_sel[0];
    assign programmed_tone_pair_b = prog_sel[1];
    assign programmed_tone_pair_c = prog_sel[2];
    assign programmed_tone_pair_d = prog_sel[3];

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    property p_dtmf_d;
        @(posedge clk) disable iff (!rstn)
        (tone_mode && tone_sel == 5'h10) |-> (tone_low_hz == 12'd941 && tone_high_hz == 12'd1633);
    endproperty
    a_dtmf_d: assert property (p_dtmf_d)
        else $error("dtmf code 0 not 941+1633");

    property p_fixed_tone;
        @(posedge clk) disable iff (!rstn)
        (tone_mode && tone_sel == 5'h0A) |-> (tone_low_hz == 12'd2100 && tone_high_hz == 12'd0);
    endproperty
    a_fixed_tone: assert property (p_fixed_tone)
        else $error("fixed tone code A not 2100 Hz");

    property p_prog_pair;
        @(posedge clk) disable iff (!rstn)
        (tone_mode && tone_sel == 5'h0F) |-> (programmed_tone_pair_d && !programmed_tone_pair_a);
    endproperty
    a_prog_pair: assert property (p_prog_pair)
        else $error("programmed pair D not selected");

endmodule
`default_nettype wire

/* hw/modem_mode_register_decode.sv */
// Serial control-bus slave holding the transmit and receive mode registers and their decode
// Contract
// - Start-stop: tx bits 2-1 give 5 to 8 data bits, bit 0 two stop bits.
// - Sync source: bit2 set is buffer data, 011 is ones, 010 is zeros.
// - Sync 00x sends dibits 00,11 at 1200 DPSK, else alternating ones and zeros.
// - Tone bank 0: silence, eight single tones, then 1300, 2100, 2225 Hz.
// - Tone bank 0 codes C to F select programmed pairs A to D.
// - Tone bank 1 selects keypad dual tones, code 0 is D.
// - Receive mode is 16-bit write-only at E2; reads return nothing.
// - General reset clears receive mode; general control bit 7 holds it clear.
// - Rx bits 15-12 choose DPSK, V.21, Bell 103, V.23, Bell 202 modes.
// - Rx code 1 enables tone detect, 0 disables; host avoids E and F.
// - Rx bits 11-9 set gain, 0 dB at 7, 1.5 dB less per step.
// - Tx bits 4-3: sync, no parity, even parity, odd parity.
// - Tx code 1 is tone transmit, code 0 disables the transmitter.
`timescale 1ns/100ps
`default_nettype none

module modem_mode_register_decode
    import modem_mode_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic bus_csn,
    input wire logic bus_sclk,
    input wire logic bus_cdata,
    output logic bus_rdata,
    output logic bus_rdata_oe,
    output logic [3:0] tx_mode_code,
    output logic tx_enabled,
    output logic tx_tone_mode,
    output logic tx_sync,
    output logic tx_parity_en,
    output logic tx_parity_odd,
    output logic [3:0] tx_data_bits,
    output logic tx_two_stop,
    output tx_source_e tx_source,
    output logic tx_pattern_dibit,
    output logic [11:0] tone_low_hz,
    output logic [11:0] tone_high_hz,
    output logic programmed_tone_pair_a,
    output logic programmed_tone_pair_b,
    output logic programmed_tone_pair_c,
    output logic programmed_tone_pair_d,
    output logic [3:0] rx_mode_code,
    output logic rx_enabled,
    output logic rx_tone_detect,
    output logic rx_dpsk1200,
    output logic rx_dpsk600,
    output logic rx_v21,
    output logic rx_bell103,
    output logic rx_v23,
    output logic rx_bell202,
    output logic rx_high_band,
    output logic rx_mode_reserved,
    output logic auto_equaliser_enable,
    output logic [2:0] rx_gain_code,
    output logic signed [7:0] rx_gain_tenth_db
);

    // ----------------------------------------------------------------
    // Serial shifter
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ADDR = 2'b01,
        ST_DATA = 2'b10,
        ST_SKIP = 2'b11
    } bus_state_e;

    bus_state_e state_q, state_d;
    logic sclk_q, sclk_d;
    logic [4:0] bit_cnt_q, bit_cnt_d;
    logic [7:0] addr_q, addr_d;
    logic [15:0] shift_q, shift_d;
    logic [15:0] gen_ctrl_q, gen_ctrl_d;
    logic [15:0] tx_mode_q, tx_mode_d;
    logic [15:0] rx_mode_q, rx_mode_d;
    logic sclk_rise;
    logic word_done;
    logic [15:0] word_in;
    logic general_reset;
    logic hold_reset;

    // Mode field of a 16-bit mode word; both registers share the layout
    function automatic logic [3:0] mode_field(input logic [15:0] w);
        mode_field = w[MODE_MSB:MODE_LSB];
    endfunction

    // Modem modes are the pairs 2 to D; the pair index drops the band bit
    function automatic logic [2:0] mode_pair(input logic [15:0] w);
        mode_pair = w[MODE_MSB:MODE_LSB + 1];
    endfunction

    // Pins are synchronous to clk, so a sampled copy of the clock pin gives its edge
    assign sclk_rise = bus_sclk && !sclk_q && !bus_csn;
    assign word_in = {shift_q[14:0], bus_cdata};
    assign word_done = (state_q == ST_DATA) && sclk_rise && (bit_cnt_q == WORD_LAST_BIT);
    // General reset is an address byte alone, ended by the select going high
    assign general_reset = bus_csn && (state_q == ST_DATA) && (bit_cnt_q == ADDR_BITS)
        && (addr_q == ADDR_GENERAL_RESET);
    assign hold_reset = gen_ctrl_q[GEN_RESET_BIT];

    always_comb
    begin
        state_d = state_q;
        sclk_d = bus_sclk;
        bit_cnt_d = bit_cnt_q;
        addr_d = addr_q;
        shift_d = shift_q;
        if (bus_csn)
        begin
            state_d = ST_IDLE;
            bit_cnt_d = 5'h00;
        end
        else
        begin
            case (state_q)
                ST_IDLE:
                begin
                    state_d = ST_ADDR;
                    bit_cnt_d = 5'h00;
                end
                ST_ADDR:
                begin
                    if (sclk_rise)
                    begin
                        addr_d = {addr_q[6:0], bus_cdata};
                        bit_cnt_d = bit_cnt_q + 5'h01;
                        if (bit_cnt_q == ADDR_LAST_BIT)
                        begin
                            state_d = ST_DATA;
                        end
                    end
                end
                ST_DATA:
                begin
                    if (sclk_rise)
                    begin
                        shift_d = word_in;
                        bit_cnt_d = bit_cnt_q + 5'h01;
                        // Further bits in the same select are ignored
                        if (word_done)
                        begin
                            state_d = ST_SKIP;
                        end
                    end
                end
                ST_SKIP:
                begin
                    state_d = ST_SKIP;
                end
                default:
                begin
                    state_d = ST_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Register file
    // ----------------------------------------------------------------
    always_comb
    begin
        gen_ctrl_d = gen_ctrl_q;
        tx_mode_d = tx_mode_q;
        rx_mode_d = rx_mode_q;
        if (word_done && addr_q == ADDR_GENERAL_CTRL)
        begin
            gen_ctrl_d = word_in;
        end
        if (word_done && addr_q == ADDR_TX_MODE)
        begin
            tx_mode_d = word_in;
        end
        if (word_done && addr_q == ADDR_RX_MODE)
        begin
            rx_mode_d = word_in;
        end
        // Reset bit is checked on the registered value, so a write that sets it clears next cycle
        if (hold_reset)
        begin
            tx_mode_d = MODE_RESET;
            rx_mode_d = MODE_RESET;
        end
        if (general_reset)
        begin
            gen_ctrl_d = MODE_RESET;
            tx_mode_d = MODE_RESET;
            rx_mode_d = MODE_RESET;
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_q <= ST_IDLE;
            sclk_q <= 1'b0;
            bit_cnt_q <= 5'h00;
            addr_q <= 8'h00;
            shift_q <= 16'h0000;
            gen_ctrl_q <= MODE_RESET;
            tx_mode_q <= MODE_RESET;
            rx_mode_q <= MODE_RESET;
        end
        else
        begin
            state_q <= state_d;
            sclk_q <= sclk_d;
            bit_cnt_q <= bit_cnt_d;
            addr_q <= addr_d;
            shift_q <= shift_d;
            gen_ctrl_q <= gen_ctrl_d;
            tx_mode_q <= tx_mode_d;
            rx_mode_q <= rx_mode_d;
        end
    end

    // Mode registers are write-only, so the reply line is never driven
    assign bus_rdata = 1'b0;
    assign bus_rdata_oe = 1'b0;

    // ----------------------------------------------------------------
    // Transmit decode
    // ----------------------------------------------------------------
    logic tx_modem;
    logic tx_is_dpsk1200;

    assign tx_mode_code = mode_field(tx_mode_q);
    assign tx_enabled = (tx_mode_code != MODE_OFF);
    assign tx_tone_mode = (tx_mode_code == MODE_TONES);
    assign tx_modem = (mode_pair(tx_mode_q) != 3'h0) && (mode_pair(tx_mode_q) != MODE_RESERVED);
    assign tx_is_dpsk1200 = (mode_pair(tx_mode_q) == MODE_DPSK1200);
    assign tx_sync = tx_modem && (tx_mode_q[FMT_MSB:FMT_LSB] == FMT_SYNC);
    assign tx_parity_en = tx_modem && (tx_mode_q[FMT_MSB:FMT_LSB] == FMT_EVEN
        || tx_mode_q[FMT_MSB:FMT_LSB] == FMT_ODD);
    assign tx_parity_odd = tx_modem && (tx_mode_q[FMT_MSB:FMT_LSB] == FMT_ODD);
    assign tx_data_bits = MIN_DATA_BITS + {2'b00, tx_mode_q[2:1]};
    assign tx_two_stop = tx_mode_q[0];

    always_comb
    begin
        tx_source = SRC_PATTERN;
        if (tx_mode_q[2])
        begin
            tx_source = SRC_BUFFER;
        end
        else if (tx_mode_q[1])
        begin
            tx_source = tx_mode_q[0] ? SRC_ONES : SRC_ZEROS;
        end
    end

    // Dibit pattern only applies to 1200 bit/s DPSK; every other mode alternates bits
    assign tx_pattern_dibit = tx_sync && (tx_source == SRC_PATTERN) && tx_is_dpsk1200;

    // Bits 8-5 are assumed zero in tone mode, so only bits 4-0 reach the decoder
    tx_tone_decode u_tone
    (
        .clk(clk),
        .rstn(rstn),
        .tone_mode(tx_tone_mode),
        .tone_sel(tx_mode_q[4:0]),
        .tone_low_hz(tone_low_hz),
        .tone_high_hz(tone_high_hz),
        .programmed_tone_pair_a(programmed_tone_pair_a),
        .programmed_tone_pair_b(programmed_tone_pair_b),
        .programmed_tone_pair_c(programmed_tone_pair_c),
        .programmed_tone_pair_d(programmed_tone_pair_d)
    );

    // ----------------------------------------------------------------
    // Receive decode
    // ----------------------------------------------------------------
    logic [7:0] gain_up;

    assign rx_mode_code = mode_field(rx_mode_q);
    assign rx_enabled = (rx_mode_code != MODE_OFF);
    assign rx_tone_detect = (rx_mode_code == MODE_TONES);
    assign rx_dpsk1200 = (mode_pair(rx_mode_q) == MODE_DPSK1200);
    assign rx_dpsk600 = (mode_pair(rx_mode_q) == MODE_DPSK600);
    assign rx_v21 = (mode_pair(rx_mode_q) == MODE_V21);
    assign rx_bell103 = (mode_pair(rx_mode_q) == MODE_BELL103);
    assign rx_v23 = (mode_pair(rx_mode_q) == MODE_V23);
    assign rx_bell202 = (mode_pair(rx_mode_q) == MODE_BELL202);
    assign rx_high_band = rx_mode_q[MODE_LSB] && (mode_pair(rx_mode_q) != 3'h0);
    // Reserved codes are flagged rather than acted on; the host must not write them
    assign rx_mode_reserved = (mode_pair(rx_mode_q) == MODE_RESERVED);
    assign auto_equaliser_enable = rx_mode_q[EQ_BIT] && (rx_dpsk1200 || rx_dpsk600);
    assign rx_gain_code = rx_mode_q[GAIN_MSB:GAIN_LSB];
    assign gain_up = 8'({5'h00, rx_gain_code} * GAIN_STEP_TENTH_DB);
    assign rx_gain_tenth_db = $signed(gain_up - GAIN_FLOOR_TENTH_DB);

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    property p_hold_clears;
        @(posedge clk) disable iff (!rstn)
        hold_reset |=> (rx_mode_q == 16'h0000 && tx_mode_q == 16'h0000);
    endproperty
    a_hold_clears: assert property (p_hold_clears)
        else $error("mode registers not held clear");

    property p_general_reset;
        @(posedge clk) disable iff (!rstn)
        general_reset |=> (rx_mode_q == 16'h0000 && gen_ctrl_q == 16'h0000);
    endproperty
    a_general_reset: assert property (p_general_reset)
        else $error("general reset did not clear");

    property p_whole_word;
        @(posedge clk) disable iff (!rstn)
        !$stable(rx_mode_q) |-> ($past(word_done) && $past(addr_q) == 8'hE2)
            || $past(hold_reset) || $past(general_reset);
    endproperty
    a_whole_word: assert property (p_whole_word)
        else $error("receive mode changed without a complete write");

    property p_no_read_drive;
        @(posedge clk) disable iff (!rstn)
        !bus_csn |-> !bus_rdata_oe;
    endproperty
    a_no_read_drive: assert property (p_no_read_drive)
        else $error("reply line driven for write-only register");

    property p_gain;
        @(posedge clk) disable iff (!rstn)
        1'b1 |-> (rx_gain_tenth_db == 8'(int'(rx_gain_code) * 15 - 105));
    endproperty
    a_gain: assert property (p_gain)
        else $error("receive gain wrong");

    property p_data_bits;
        @(posedge clk) disable iff (!rstn)
        (tx_modem && !tx_sync) |-> (tx_data_bits == 4'(5 + tx_mode_q[2:1]));
    endproperty
    a_data_bits: assert property (p_data_bits)
        else $error("data bit count wrong");

    property p_sync_source;
        @(posedge clk) disable iff (!rstn)
        (tx_sync && tx_mode_q[2:0] == 3'b011) |-> (tx_source == SRC_ONES);
    endproperty
    a_sync_source: assert property (p_sync_source)
        else $error("sync source not ones");

    property p_dibit;
        @(posedge clk) disable iff (!rstn)
        (tx_sync && tx_mode_q[2:1] == 2'b00) |-> (tx_pattern_dibit == (tx_mode_q[15:13] == 3'b110));
    endproperty
    a_dibit: assert property (p_dibit)
        else $error("pattern choice wrong");

    property p_odd_parity;
        @(posedge clk) disable iff (!rstn)
        (tx_modem && tx_mode_q[4:3] == 2'b00) |-> (tx_parity_en && tx_parity_odd && !tx_sync);
    endproperty
    a_odd_parity: assert property (p_odd_parity)
        else $error("odd parity format wrong");

    property p_rx_mode;
        @(posedge clk) disable iff (!rstn)
        (rx_mode_q[15:12] == 4'hD) |-> (rx_dpsk1200 && rx_high_band && rx_enabled);
    endproperty
    a_rx_mode: assert property (p_rx_mode)
        else $error("rx code D decode wrong");

    property p_tx_off;
        @(posedge clk) disable iff (!rstn)
        (tx_mode_q[15:12] == 4'h0) |-> (!tx_enabled && !tx_tone_mode && !tx_sync);
    endproperty
    a_tx_off: assert property (p_tx_off)
        else $error("disabled transmitter decode wrong");

endmodule
`default_nettype wire

/* tb/host_bus_model.sv */
// Host model that drives the serial control bus
`timescale 1ns/100ps
`default_nettype none
module host_bus_model (
    input wire logic clk,
    output logic bus_csn,
    output logic bus_sclk,
    output logic bus_cdata
);
    initial
    begin
        bus_csn = 1'b1;
        bus_sclk = 1'b0;
        bus_cdata = 1'b1;
    end
    // Writes only, MSB first; a short count leaves a partial word behind
    task automatic send(input logic [23:0] frame, input int n);
        @(negedge clk) bus_csn = 1'b0;
        @(negedge clk);
        for (int i = 23; i > 23 - n; i--)
        begin
            @(negedge clk) bus_sclk = 1'b0;
            bus_cdata = frame[i];
            @(negedge clk) bus_sclk = 1'b1;
        end
        // Data line flips after the frame so a stale bit is never mistaken for a held one
        @(negedge clk) bus_sclk = 1'b0;
        bus_cdata = ~bus_cdata;
        @(negedge clk) bus_csn = 1'b1;
        @(negedge clk);
    endtask
endmodule
`default_nettype wire

/* tb/testbench.sv */
// Self-checking bench for the mode register decode
`timescale 1ns/100ps
`default_nettype none
module testbench import modem_mode_pkg::*;;
    logic clk = 1'b0, rstn = 1'b0, bus_csn, bus_sclk, bus_cdata, bus_rdata, bus_rdata_oe;
    logic tx_enabled, tx_tone_mode, tx_sync, tx_parity_en, tx_parity_odd, tx_two_stop;
    logic tx_pattern_dibit, rx_enabled, rx_tone_detect, rx_dpsk1200, rx_dpsk600, rx_v21;
    logic rx_bell103, rx_v23, rx_bell202, programmed_tone_pair_a, programmed_tone_pair_b;
    logic programmed_tone_pair_c, programmed_tone_pair_d;
    logic rx_high_band, rx_mode_reserved, auto_equaliser_enable;
    logic [3:0] tx_mode_code, tx_data_bits, rx_mode_code;
    logic [11:0] tone_low_hz, tone_high_hz;
    logic [2:0] rx_gain_code;
    logic signed [7:0] rx_gain_tenth_db;
    tx_source_e tx_source;
    int errors = 0, n_checks = 0, cycles = 0;
    host_bus_model host (.clk, .bus_csn, .bus_sclk, .bus_cdata);
    modem_mode_register_decode uut (.clk, .rstn, .bus_csn, .bus_sclk, .bus_cdata, .bus_rdata,
        .bus_rdata_oe, .tx_mode_code, .tx_enabled, .tx_tone_mode, .tx_sync, .tx_parity_en,
        .tx_parity_odd, .tx_data_bits, .tx_two_stop, .tx_source, .tx_pattern_dibit,
        .tone_low_hz, .tone_high_hz, .programmed_tone_pair_a, .programmed_tone_pair_b,
        .programmed_tone_pair_c, .programmed_tone_pair_d, .rx_mode_code, .rx_enabled,
        .rx_tone_detect, .rx_dpsk1200, .rx_dpsk600, .rx_v21, .rx_bell103, .rx_v23, .rx_bell202,
        .rx_high_band, .rx_mode_reserved, .auto_equaliser_enable, .rx_gain_code,
        .rx_gain_tenth_db);
    always #4 clk = ~clk;
    // Whole run needs about 6300 cycles
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            errors++;
            summarize();
        end
    end
    task automatic summarize();
        if (errors == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] addr, input logic [15:0] data);
        host.send({addr, data}, 24);
    endtask
    task automatic tones();
        logic [11:0] s0 [16] = '{HZ_NONE, HZ_697, HZ_770, HZ_852, HZ_941, HZ_1209, HZ_1336,
            HZ_1477, HZ_1633, HZ_1300, HZ_2100, HZ_2225, HZ_NONE, HZ_NONE, HZ_NONE, HZ_NONE};
        logic [11:0] lo [16] = '{HZ_941, HZ_697, HZ_697, HZ_697, HZ_770, HZ_770, HZ_770, HZ_852,
            HZ_852, HZ_852, HZ_941, HZ_941, HZ_941, HZ_697, HZ_770, HZ_852};
        logic [11:0] hi [16] = '{HZ_1633, HZ_1209, HZ_1336, HZ_1477, HZ_1209, HZ_1336, HZ_1477,
            HZ_1209, HZ_1336, HZ_1477, HZ_1336, HZ_1209, HZ_1477, HZ_1633, HZ_1633, HZ_1633};
        for (int i = 0; i < 32; i++)
        begin
            wr(ADDR_TX_MODE, {MODE_TONES, 7'h00, 5'(i)});
            check({tx_mode_code, 2'b00, tx_enabled, tx_tone_mode}, 16'h0013);
            check(tone_low_hz, i < 16 ? s0[i] : lo[i - 16]);
            check(tone_high_hz, i < 16 ? 12'h000 : hi[i - 16]);
            check({programmed_tone_pair_a, programmed_tone_pair_b, programmed_tone_pair_c,
                programmed_tone_pair_d}, (i >= 12 && i < 16) ? 4'h8 >> (i - 12) : 4'h0);
        end
    endtask
    task automatic formats();
        logic [3:0] m;
        tx_source_e src;
        for (int i = 0; i < 64; i++)
        begin
            m = i[5] ? 4'hD : 4'h2;
            src = i[2] ? SRC_BUFFER : i[1] ? (i[0] ? SRC_ONES : SRC_ZEROS) : SRC_PATTERN;
            wr(ADDR_TX_MODE, {m, 7'h00, i[4:0]});
            check({tx_sync, tx_parity_en, tx_parity_odd, tx_two_stop, tx_data_bits}, {i[4:3]
                == 2'b11, !i[4], i[4:3] == 2'b00, i[0], 4'h5 + 4'(i[2:1])});
            check({tx_mode_code, tx_enabled, tx_tone_mode}, {m, 2'b10});
            if (i[4:3] == 2'b11)
                check({tx_source, tx_pattern_dibit},
                    {src, src == SRC_PATTERN && m[3]});
        end
    endtask
    task automatic rx_modes();
        logic [7:0] e;
        int g;
        for (int m = 0; m < 14; m++)
        begin
            g = (m ^ 5) % 8;
            e = {m != 0, m == 1, 6'h00};
            if (m > 1)
                e[m / 2 - 1] = 1'b1;
            wr(ADDR_RX_MODE, {4'(m), 3'(g), m[0], 8'h00});
            check({rx_enabled, rx_tone_detect, rx_dpsk1200, rx_dpsk600, rx_v21, rx_bell103,
                rx_v23, rx_bell202}, e);
            check({rx_high_band, rx_mode_reserved, auto_equaliser_enable},
                {m[0] && m > 1, 1'b0, m[0] && m > 9});
            check({rx_gain_code, rx_gain_tenth_db}, {3'(g), 8'(g * 15 - 105)});
            check({rx_mode_code, bus_rdata, bus_rdata_oe}, {4'(m), 2'b00});
        end
    endtask
    task automatic clears();
        wr(ADDR_TX_MODE, 16'h1005);
        wr(ADDR_RX_MODE, 16'hDE00);
        host.send({ADDR_GENERAL_RESET, 16'h0000}, 8);
        check({tx_mode_code, rx_mode_code, rx_gain_tenth_db}, 16'h0097);
        wr(ADDR_GENERAL_CTRL, 16'h0080);
        wr(ADDR_RX_MODE, 16'h1E00);
        check(rx_mode_code, 4'h0);
        wr(ADDR_GENERAL_CTRL, 16'h0000);
        // A cut frame must leave the previous word in place, so start from a nonzero one
        wr(ADDR_RX_MODE, 16'hDE00);
        host.send({ADDR_RX_MODE, 16'h1E00}, 20);
        check(rx_mode_code, 4'hD);
        wr(ADDR_RX_MODE, 16'h1E00);
        check(rx_mode_code, 4'h1);
    endtask
    initial
    begin
        repeat (10) @(negedge clk);
        rstn = 1'b1;
        tones();
        formats();
        rx_modes();
        clears();
        summarize();
    end
endmodule
`default_nettype wire
